/* File: rtl/pursq_pkg.sv */
/*
  constants and carrier types for the power-up reset sequencer.
  assumes a single 40 MHz clock domain and a classic wishbone master.
*/
package pursq_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned PWRUP_DELAY_MS = 72;
  localparam longint unsigned PWRUP_CYCLES_L = longint'(PWRUP_DELAY_MS) * CLK_HZ / 1000;
  localparam int unsigned PWRUP_CYCLES = int'(PWRUP_CYCLES_L);
  localparam int unsigned OSC_START_COUNT = 1024;
  localparam int unsigned BOR_MIN_NS = 100;
  localparam int unsigned BOR_MIN_CYCLES = (BOR_MIN_NS * 40 + 999) / 1000;
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int unsigned CFG_DELAY_DIS_BIT = 0;
  localparam int unsigned CFG_BOR_EN_BIT = 1;
  localparam int unsigned CFG_MODE_LSB = 2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    PURSQ_OSC_EXT_RC, PURSQ_OSC_LOWPOWER, PURSQ_OSC_STANDARD, PURSQ_OSC_HIGHSPEED
  } pursq_osc_mode_e;
  typedef enum {
    PURSQ_ST_SUPPLY_WAIT, PURSQ_ST_DELAY, PURSQ_ST_OSC_COUNT, PURSQ_ST_RUN
  } pursq_state_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pursq_wb_req_s;
endpackage : pursq_pkg

/* File: rtl/pursq_sequencer.sv */
/*
  power-up reset sequencer: supply detector, brown-out filter, delay timer,
  oscillator start-up count and a wishbone register slave.
  assumes comparator and pin inputs already synchronous to clk_sys.
*/
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pursq_sequencer
  import pursq_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES_P = PWRUP_CYCLES
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire pursq_wb_req_s wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic supplyAbovePorThreshold,
  input wire logic supplyBelowBrownoutThreshold,
  input wire logic externalResetPinN,
  input wire logic oscillatorInputRise,
  input wire logic wakeFromSleep,
  output logic coreReset,
  output logic programRun
);
  logic [31:0] cfg_r;
  logic porSeen_r;
  logic [7:0] borCnt_r;
  logic borTrip_r;
  logic [31:0] delayCnt_r;
  logic [10:0] oscCnt_r;
  logic fromPor_r;
  logic oscPending_r;
  pursq_state_e state_r;
  logic delayDisable;
  logic borEnable;
  logic crystalMode;
  logic anySource;
  logic wbHit;

  function automatic logic isCrystal(input logic [1:0] m);
    isCrystal = (m != 2'(PURSQ_OSC_EXT_RC));
  endfunction : isCrystal

  assign delayDisable = cfg_r[CFG_DELAY_DIS_BIT];
  assign borEnable = cfg_r[CFG_BOR_EN_BIT];
  assign crystalMode = isCrystal(cfg_r[CFG_MODE_LSB +: 2]);
  // ack in the hit term stops a held request from being taken twice
  assign wbHit = wbReq.cyc && wbReq.stb && !wbAck;
  // brown-out and pin act as sources; supply fall never clears porSeen
  assign anySource = !porSeen_r || borTrip_r || !externalResetPinN;

  // wishbone slave, one wait state; unmapped reads return zero
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
      cfg_r <= CFG_RESET;
    end
    else
    begin
      wbAck <= wbHit;
      wbDatOut <= 32'h0000_0000;
      if (wbHit && wbReq.we && wbReq.adr == CFG_OFFSET && wbReq.sel[0])
      begin
        cfg_r <= {28'h0000000, wbReq.dat[3:0]};
      end
      if (wbHit && !wbReq.we)
      begin
        if (wbReq.adr == CFG_OFFSET)
        begin
          wbDatOut <= cfg_r;
        end
        else if (wbReq.adr == STATUS_OFFSET)
        begin
          wbDatOut <= {26'h0, borTrip_r, porSeen_r, 2'(state_r), coreReset, programRun};
        end
      end
    end
  end

  // power-on detector latches on the rising supply only
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      porSeen_r <= 1'b0;
    end
    else if (supplyAbovePorThreshold)
    begin
      porSeen_r <= 1'b1;
    end
  end

  // brown-out filter: short dips are ignored, trip clears when supply recovers
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      borCnt_r <= 8'h00;
      borTrip_r <= 1'b0;
    end
    else if (!borEnable || !supplyBelowBrownoutThreshold)
    begin
      borCnt_r <= 8'h00;
      borTrip_r <= 1'b0;
    end
    else if (borCnt_r >= 8'(BOR_MIN_CYCLES))
    begin
      borTrip_r <= 1'b1;
    end
    else
    begin
      borCnt_r <= borCnt_r + 8'h01;
    end
  end

  // sequence; the delay counter is a stand-in for the internal rc oscillator
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_r <= PURSQ_ST_SUPPLY_WAIT;
      delayCnt_r <= 32'h0000_0000;
      oscCnt_r <= 11'h000;
      fromPor_r <= 1'b1;
      oscPending_r <= 1'b0;
    end
    else
    begin
      if (wakeFromSleep && state_r == PURSQ_ST_RUN && crystalMode)
      begin
        state_r <= PURSQ_ST_OSC_COUNT;
        oscCnt_r <= 11'h000;
      end
      else if (anySource)
      begin
        state_r <= PURSQ_ST_SUPPLY_WAIT;
        delayCnt_r <= 32'h0000_0000;
        oscCnt_r <= 11'h000;
        // origin decides whether the start-up count follows the delay
        if (!porSeen_r)
        begin
          fromPor_r <= 1'b1;
        end
        else if (borTrip_r && state_r != PURSQ_ST_SUPPLY_WAIT)
        begin
          fromPor_r <= 1'b0;
        end
      end
      else
      begin
        case (state_r)
          PURSQ_ST_SUPPLY_WAIT:
          begin
            delayCnt_r <= 32'h0000_0000;
            oscPending_r <= fromPor_r && crystalMode;
            if (!delayDisable)
            begin
              state_r <= PURSQ_ST_DELAY;
            end
            else if (fromPor_r && crystalMode)
            begin
              state_r <= PURSQ_ST_OSC_COUNT;
            end
            else
            begin
              state_r <= PURSQ_ST_RUN;
            end
          end
          PURSQ_ST_DELAY:
          begin
            // long default keeps 72 ms at clk_sys; simulation overrides it
            delayCnt_r <= delayCnt_r + 32'h0000_0001;
            if (delayCnt_r >= PWRUP_CYCLES_P - 1)
            begin
              state_r <= oscPending_r ? PURSQ_ST_OSC_COUNT : PURSQ_ST_RUN;
            end
          end
          PURSQ_ST_OSC_COUNT:
          begin
            if (oscillatorInputRise)
            begin
              oscCnt_r <= oscCnt_r + 11'h001;
              if (oscCnt_r == 11'(OSC_START_COUNT - 1))
              begin
                state_r <= PURSQ_ST_RUN;
              end
            end
          end
          default:
          begin
            fromPor_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // outputs registered; core reset released only in the run state
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      coreReset <= 1'b1;
      programRun <= 1'b0;
    end
    else
    begin
      coreReset <= !(state_r == PURSQ_ST_RUN && !anySource);
      programRun <= state_r == PURSQ_ST_RUN && !anySource;
    end
  end

  // reset sources and supply detector
  a_reset_before_por: assert property (@(posedge clk_sys) disable iff (reset)
    !porSeen_r |=> coreReset) else $error("core released before power-on");
  a_por_wait: assert property (@(posedge clk_sys) disable iff (reset)
    !porSeen_r |=> state_r == PURSQ_ST_SUPPLY_WAIT) else $error("left wait before power-on");
  a_por_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    porSeen_r |=> porSeen_r) else $error("power-on detector cleared");
  a_pin_reset: assert property (@(posedge clk_sys) disable iff (reset)
    !externalResetPinN |=> coreReset) else $error("released with pin low");
  a_release_clean: assert property (@(posedge clk_sys) disable iff (reset)
    anySource |=> coreReset) else $error("released with source active");
  a_run_pair: assert property (@(posedge clk_sys) disable iff (reset)
    programRun == !coreReset) else $error("run and reset disagree");
  a_run_release: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_RUN && !anySource |=> !coreReset) else $error("run not released");

  // power-up delay; a brown-out trip restarts it from zero
  a_delay_holds: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_DELAY |=> coreReset) else $error("reset low during delay");
  a_delay_entry: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_SUPPLY_WAIT && !anySource && !delayDisable
    |=> state_r == PURSQ_ST_DELAY && delayCnt_r == 32'h0) else $error("delay not started");
  a_delay_count: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_DELAY && !anySource
    |=> delayCnt_r == $past(delayCnt_r) + 32'h0000_0001) else $error("delay count slipped");
  a_delay_full: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_DELAY && !anySource && delayCnt_r < PWRUP_CYCLES_P - 1
    |=> state_r == PURSQ_ST_DELAY) else $error("delay ended early");
  a_delay_exit: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_DELAY && !anySource && delayCnt_r >= PWRUP_CYCLES_P - 1
    |=> state_r != PURSQ_ST_DELAY) else $error("delay overran");
  a_disable_skips: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_SUPPLY_WAIT && delayDisable |=> state_r != PURSQ_ST_DELAY)
    else $error("delay ran while disabled");
  a_bor_restart: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_DELAY && borTrip_r |=> state_r == PURSQ_ST_SUPPLY_WAIT
    && delayCnt_r == 32'h0) else $error("delay not reinitialised");

  // oscillator start-up count
  a_osc_needs_crystal: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(state_r == PURSQ_ST_OSC_COUNT) |-> crystalMode)
    else $error("start-up count outside crystal mode");
  a_origin_skip: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_SUPPLY_WAIT && !fromPor_r |=> state_r != PURSQ_ST_OSC_COUNT)
    else $error("start-up count after brown-out");
  a_wake_count: assert property (@(posedge clk_sys) disable iff (reset)
    wakeFromSleep && state_r == PURSQ_ST_RUN && crystalMode
    |=> state_r == PURSQ_ST_OSC_COUNT && oscCnt_r == 11'h000) else $error("wake missed");
  a_osc_step: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_OSC_COUNT && oscillatorInputRise && !anySource
    |=> oscCnt_r == $past(oscCnt_r) + 11'h001) else $error("rise not counted");
  a_osc_hold: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_OSC_COUNT && !oscillatorInputRise && !anySource
    |=> oscCnt_r == $past(oscCnt_r)) else $error("count moved without rise");
  a_osc_complete: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_OSC_COUNT && !(oscillatorInputRise && oscCnt_r == 11'h3FF)
    && !anySource |=> state_r != PURSQ_ST_RUN) else $error("early run");
  a_osc_finish: assert property (@(posedge clk_sys) disable iff (reset)
    state_r == PURSQ_ST_OSC_COUNT && oscillatorInputRise && !anySource
    && oscCnt_r == 11'(OSC_START_COUNT - 1) |=> state_r == PURSQ_ST_RUN) else $error("late run");

  // brown-out filter
  a_bor_off: assert property (@(posedge clk_sys) disable iff (reset)
    !borEnable |=> !borTrip_r) else $error("brown-out tripped while disabled");
  a_bor_trip: assert property (@(posedge clk_sys) disable iff (reset)
    borEnable && supplyBelowBrownoutThreshold [*6] |=> borTrip_r)
    else $error("brown-out missed long dip");
  a_bor_clear: assert property (@(posedge clk_sys) disable iff (reset)
    !supplyBelowBrownoutThreshold |=> !borTrip_r) else $error("trip kept after recovery");

  // register slave: one ack per hit, one cycle later
  a_ack_answer: assert property (@(posedge clk_sys) disable iff (reset)
    wbReq.cyc && wbReq.stb && !wbAck |=> wbAck) else $error("request not answered");
  a_ack_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    wbAck |=> !wbAck) else $error("ack longer than one cycle");
  a_cfg_write: assert property (@(posedge clk_sys) disable iff (reset)
    wbHit && wbReq.we && wbReq.adr == CFG_OFFSET && wbReq.sel[0]
    |=> cfg_r[3:0] == $past(wbReq.dat[3:0])) else $error("config write lost");
  a_cfg_keep: assert property (@(posedge clk_sys) disable iff (reset)
    !(wbHit && wbReq.we && wbReq.adr == CFG_OFFSET && wbReq.sel[0])
    |=> cfg_r == $past(cfg_r)) else $error("config changed without write");
  a_unmapped: assert property (@(posedge clk_sys) disable iff (reset)
    wbHit && !wbReq.we && wbReq.adr != CFG_OFFSET && wbReq.adr != STATUS_OFFSET
    |=> wbDatOut == 32'h0000_0000) else $error("unmapped read not zero");
  a_status_read: assert property (@(posedge clk_sys) disable iff (reset)
    wbHit && !wbReq.we && wbReq.adr == STATUS_OFFSET
    |=> wbDatOut[1:0] == $past({coreReset, programRun})) else $error("status read wrong");
endmodule : pursq_sequencer
`default_nettype wire

/* File: verif/pursq_osc_model.sv */
/*
  far-side oscillator model: one rise pulse every second clock while running.
  assumes the bench starts and stops it.
*/
`timescale 1ns/1ps
`default_nettype none
module pursq_osc_model (
  input wire logic clk_sys,
  input wire logic oscRun,
  output logic oscillatorInputRise
);
  // a crystal is silent until it starts, so no pulse leaks while stopped
  always_ff @(posedge clk_sys)
  begin
    oscillatorInputRise <= oscRun & ~oscillatorInputRise;
  end
endmodule : pursq_osc_model
`default_nettype wire

/* File: verif/pursq_sequencer_tb_top.sv */
/*
  bench for the reset sequencer: bus, supply, brown-out and start-up count.
  assumes pursq_osc_model as the oscillator on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module pursq_sequencer_tb_top;
  import pursq_pkg::*;
  localparam int DLY = 20;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  pursq_wb_req_s wbReq = '0;
  logic [31:0] wbDatOut;
  logic wbAck, coreReset, programRun, oscRise;
  logic porUp = 1'b0, brownLow = 1'b0, pinN = 1'b1, oscRun = 1'b0, wake = 1'b0;
  logic [31:0] expQ[$];
  int n_fail = 0;
  int total_checks = 0;
  int dip;
  initial forever #12.5 clk_sys = ~clk_sys;
  pursq_sequencer #(.PWRUP_CYCLES_P(DLY)) pursq_sequencer_i (.clk_sys(clk_sys),
    .reset(reset), .wbReq(wbReq), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .supplyAbovePorThreshold(porUp), .supplyBelowBrownoutThreshold(brownLow),
    .externalResetPinN(pinN), .oscillatorInputRise(oscRise), .wakeFromSleep(wake),
    .coreReset(coreReset), .programRun(programRun));
  pursq_osc_model pursq_osc_model_i (.clk_sys(clk_sys), .oscRun(oscRun),
    .oscillatorInputRise(oscRise));
  task automatic miss(input string m);
    n_fail++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : miss
  task automatic chk(input logic v, input string m);
    total_checks++;
    if (coreReset !== v || programRun !== !v)
      miss(m);
  endtask : chk
  task automatic hold(input logic v, input int n, input string m);
    repeat (n)
    begin
      @(posedge clk_sys);
      chk(v, m);
    end
  endtask : hold
  task automatic rel(input int lim, input string m);
    int n;
    n = 0;
    while (coreReset !== 1'b0 && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(1'b0, m);
  endtask : rel
  // the wait for ack is left to the watchdog on purpose
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    if (!we)
      expQ.push_back(d);
    @(posedge clk_sys);
    wbReq <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do
      @(posedge clk_sys);
    while (wbAck !== 1'b1);
    wbReq <= '0;
  endtask : wb
  task automatic dipFor(input int n);
    brownLow <= 1'b1;
    repeat (n) @(posedge clk_sys);
    brownLow <= 1'b0;
  endtask : dipFor
  always @(posedge clk_sys)
  begin
    if (wbAck === 1'b1 && wbReq.we === 1'b0)
    begin
      total_checks++;
      if (expQ.size() == 0 || wbDatOut !== expQ.pop_front())
        miss("read data");
    end
  end
  initial
  begin
    void'($urandom(77));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    hold(1'b1, 40, "no supply");
    wb(1'b0, CFG_OFFSET, CFG_RESET);
    wb(1'b1, 8'h08, 32'hF);
    wb(1'b0, 8'h08, 32'h0);
    porUp <= 1'b1;
    hold(1'b1, DLY + 3, "delay");
    rel(2, "power-on");
    porUp <= 1'b0;
    hold(1'b0, 20, "supply fall");
    porUp <= 1'b1;
    pinN <= 1'b0;
    @(posedge clk_sys);
    hold(1'b1, 10, "pin low");
    pinN <= 1'b1;
    hold(1'b1, DLY, "pin delay");
    rel(4, "pin release");
    $display("test power-on done");
    dipFor(12);
    hold(1'b0, 12, "brown-out off");
    wb(1'b1, CFG_OFFSET, 32'h2); // delay kept on with brown-out
    dip = 1 + $urandom % 3;
    dipFor(dip);
    hold(1'b0, 10, "short dip");
    dipFor(12);
    chk(1'b1, "long dip");
    hold(1'b1, DLY / 2, "bo delay");
    dipFor(12);
    hold(1'b1, DLY - 2, "restart");
    rel(DLY + 8, "bo release");
    wb(1'b1, CFG_OFFSET, 32'h3);
    wb(1'b0, CFG_OFFSET, 32'h3);
    dipFor(12);
    rel(8, "delay off");
    $display("test brown-out done");
    for (int m = 1; m < 4; m++)
    begin
      reset <= 1'b1;
      porUp <= 1'b0;
      oscRun <= 1'b0;
      @(posedge clk_sys);
      reset <= 1'b0;
      wb(1'b1, CFG_OFFSET, 32'(m << CFG_MODE_LSB));
      porUp <= 1'b1;
      hold(1'b1, DLY + 40, "osc stopped");
      oscRun <= 1'b1;
      hold(1'b1, 2000, "osc count");
      rel(100, "osc done");
      $display("test crystal mode %0d done", m);
    end
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    @(posedge clk_sys);
    hold(1'b1, 2000, "wake count");
    rel(100, "wake done");
    oscRun <= 1'b0;
    wb(1'b1, CFG_OFFSET, 32'hE); // delay kept on with brown-out
    dipFor(12);
    chk(1'b1, "crystal dip");
    rel(DLY + 8, "no count after brown-out");
    $display("test wake and brown-out origin done");
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miss("timeout");
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
endmodule : pursq_sequencer_tb_top
`default_nettype wire
